// ### logic/adlc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module adlc_regs #(
    parameter int ADDR_W = 12,
    parameter int ADC_W = 12,
    parameter int LINK_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cal_enable,
    input wire logic mode_is_64b66b,
    input wire logic [7:0] mode_e,
    input wire logic [7:0] mode_f,
    input wire logic frame_tick,
    input wire logic sysref,
    input wire logic [ADC_W-1:0] adc_sample,
    input wire logic timestamp_in,
    output logic dither_enable,
    output logic dither_amplitude_select,
    output logic dither_rounding_select,
    output logic link_enable,
    output logic link_reset_n,
    output logic serializer_power_down,
    output logic link_clock_enable,
    output logic [adlc_pkg::MODE_MSB:0] link_output_mode,
    output logic [15:0] multiframe_length,
    output logic multiframe_boundary,
    output logic ila_control_bits_zero,
    output logic [LINK_W-1:0] link_sample
);
    import adlc_pkg::*;

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie in 12..32");
    end
    if (LINK_W < ADC_W || ADC_W < 2) begin : g_bad_width
        $error("LINK_W must not be narrower than ADC_W");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic w_have;
        logic [9:0] aw_idx;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] dither;
        logic [7:0] lsb_ctrl;
        logic [7:0] link_en;
        logic [7:0] mode;
        logic [7:0] km1;
        logic [15:0] k_eff;
        logic [15:0] mf_cnt;
        logic mf_edge;
        logic ila_cs_zero;
        logic [LINK_W-1:0] sample;
    } adlc_state_s;

    adlc_state_s st_ff;
    adlc_state_s nxt_st;
    logic [15:0] k_calc;
    logic [9:0] ar_idx;
    logic [LINK_W-1:0] widened;

    assign ar_idx = s_axi_araddr[11:2];

    // ----------------------------------------
    // Multiframe length and sample mapping
    // ----------------------------------------
    always_comb begin
        k_calc = 16'({8'h00, st_ff.km1} + 16'h0001);
        if (mode_is_64b66b) begin
            // Zero F is an illegal mode; keep the counter finite
            if (mode_f == 8'h00) begin
                k_calc = MF_SCALE;
            end else begin
                k_calc = 16'((MF_SCALE * {8'h00, mode_e}) / {8'h00, mode_f});
            end
        end
        // Converter sample sits in the top bits of the link field
        widened = '0;
        widened[LINK_W-1 -: ADC_W] = adc_sample;
        if (st_ff.lsb_ctrl[BIT_TS_EN]) begin
            // Only the lowest link bit is replaced; wide fields keep the ADC LSB
            widened[0] = timestamp_in;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic do_write;
        logic link_on;
        do_write = 1'b0;
        link_on = 1'b0;
        nxt_st = st_ff;

        // Write address and data taken in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_idx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.w_byte = s_axi_wdata[7:0];
            nxt_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
            do_write = 1'b1;
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = RESP_OKAY;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // Whole byte stored, reserved bits too, so reads echo writes
        if (do_write) begin
            unique case (st_ff.aw_idx)
                IDX_DITHER: begin
                    if (st_ff.w_lane0) nxt_st.dither = st_ff.w_byte;
                end
                IDX_LSB: begin
                    if (st_ff.w_lane0) nxt_st.lsb_ctrl = st_ff.w_byte;
                end
                IDX_LINK_EN: begin
                    if (st_ff.w_lane0) nxt_st.link_en = st_ff.w_byte;
                end
                IDX_MODE: begin
                    if (st_ff.w_lane0) nxt_st.mode = st_ff.w_byte;
                end
                IDX_KM1: begin
                    if (st_ff.w_lane0) nxt_st.km1 = st_ff.w_byte;
                end
                IDX_STATUS, IDX_KEFF: begin
                end
                default: begin
                    nxt_st.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Read channel, one outstanding
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = RESP_OKAY;
            nxt_st.rdata = 32'h0000_0000;
            unique case (ar_idx)
                IDX_DITHER: nxt_st.rdata[7:0] = st_ff.dither;
                IDX_LSB: nxt_st.rdata[7:0] = st_ff.lsb_ctrl;
                IDX_LINK_EN: nxt_st.rdata[7:0] = st_ff.link_en;
                IDX_MODE: nxt_st.rdata[7:0] = st_ff.mode;
                IDX_KM1: nxt_st.rdata[7:0] = st_ff.km1;
                IDX_STATUS: nxt_st.rdata[3:0] = {mode_is_64b66b, cal_enable,
                    st_ff.link_en[BIT_LINK_EN], st_ff.mf_edge};
                IDX_KEFF: nxt_st.rdata[15:0] = st_ff.k_eff;
                default: nxt_st.rresp = RESP_SLVERR;
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end

        nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_have && !nxt_st.bvalid;
        nxt_st.arready = !nxt_st.rvalid;

        // Multiframe counter frozen at zero while the link is off
        link_on = st_ff.link_en[BIT_LINK_EN];
        nxt_st.k_eff = k_calc;
        nxt_st.mf_edge = 1'b0;
        if (!link_on) begin
            nxt_st.mf_cnt = 16'h0000;
        end else if (sysref) begin
            nxt_st.mf_cnt = 16'h0000;
            nxt_st.mf_edge = 1'b1;
        end else if (frame_tick) begin
            if (st_ff.mf_cnt >= 16'(st_ff.k_eff - 16'h0001)) begin
                nxt_st.mf_cnt = 16'h0000;
                nxt_st.mf_edge = 1'b1;
            end else begin
                nxt_st.mf_cnt = 16'(st_ff.mf_cnt + 16'h0001);
            end
        end

        // Sample and timestamp share one register stage
        nxt_st.sample = widened;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
            st_ff.dither <= RST_DITHER;
            st_ff.lsb_ctrl <= RST_LSB;
            st_ff.link_en <= RST_LINK_EN;
            st_ff.mode <= RST_MODE;
            st_ff.km1 <= RST_KM1;
            st_ff.ila_cs_zero <= 1'b1;
            st_ff.k_eff <= 16'({8'h00, RST_KM1} + 16'h0001);
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rdata = st_ff.rdata;
    assign dither_enable = st_ff.dither[BIT_DITH_EN];
    assign dither_amplitude_select = st_ff.dither[BIT_DITH_AMP];
    assign dither_rounding_select = st_ff.dither[BIT_DITH_RND];
    assign link_enable = st_ff.link_en[BIT_LINK_EN];
    assign link_reset_n = st_ff.link_en[BIT_LINK_EN];
    assign serializer_power_down = ~st_ff.link_en[BIT_LINK_EN];
    assign link_clock_enable = st_ff.link_en[BIT_LINK_EN];
    assign link_output_mode = st_ff.mode[MODE_MSB:0];
    assign multiframe_length = st_ff.k_eff;
    assign multiframe_boundary = st_ff.mf_edge;
    // Marker never advertised, lane alignment shows zero control bits
    assign ila_control_bits_zero = st_ff.ila_cs_zero;
    assign link_sample = st_ff.sample;
endmodule
`default_nettype wire

// ### logic/adlc_pkg.sv
package adlc_pkg;
    // ----------------------------------------
    // Register indices, byte address is four times
    // ----------------------------------------
    localparam logic [9:0] IDX_DITHER = 10'h09D;
    localparam logic [9:0] IDX_LSB = 10'h160;
    localparam logic [9:0] IDX_LINK_EN = 10'h200;
    localparam logic [9:0] IDX_MODE = 10'h201;
    localparam logic [9:0] IDX_KM1 = 10'h202;
    localparam logic [9:0] IDX_STATUS = 10'h210;
    localparam logic [9:0] IDX_KEFF = 10'h211;
    // ----------------------------------------
    // Reset values and field positions
    // ----------------------------------------
    localparam logic [7:0] RST_DITHER = 8'h00;
    localparam logic [7:0] RST_LSB = 8'h00;
    localparam logic [7:0] RST_LINK_EN = 8'h01;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_KM1 = 8'h1F;
    localparam int BIT_DITH_EN = 0;
    localparam int BIT_DITH_AMP = 1;
    localparam int BIT_DITH_RND = 2;
    localparam int BIT_TS_EN = 0;
    localparam int BIT_LINK_EN = 0;
    localparam int MODE_MSB = 5;
    localparam logic [15:0] MF_SCALE = 16'h0100;
    // ----------------------------------------
    // Bus answers
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### test/adlc_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adlc_regs_properties #(
    parameter int ADC_W = 12,
    parameter int LINK_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sysref,
    input wire logic mode_is_64b66b,
    input wire logic [7:0] mode_e,
    input wire logic [7:0] mode_f,
    input wire logic [ADC_W-1:0] adc_sample,
    input wire logic link_enable,
    input wire logic link_reset_n,
    input wire logic serializer_power_down,
    input wire logic link_clock_enable,
    input wire logic [15:0] multiframe_length,
    input wire logic multiframe_boundary,
    input wire logic ila_control_bits_zero,
    input wire logic [LINK_W-1:0] link_sample
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Link gating
    // ----------------------------------------
    link_reset_a: assert property (link_reset_n == link_enable)
        else $error("link reset does not follow enable");
    link_off_a: assert property (!link_enable |-> serializer_power_down && !link_clock_enable)
        else $error("link powered while disabled");
    link_on_a: assert property (link_enable |-> !serializer_power_down && link_clock_enable)
        else $error("link gated while enabled");
    // Two cycles, a pulse decided just before the disable may still land
    held_count_a: assert property (!link_enable [*2] |-> !multiframe_boundary)
        else $error("boundary while link disabled");
    sysref_align_a: assert property (link_enable && sysref |=> multiframe_boundary)
        else $error("sysref did not realign");
    ila_zero_a: assert property (ila_control_bits_zero)
        else $error("control bits not zero");
    // ----------------------------------------
    // Data paths
    // ----------------------------------------
    sample_lat_a: assert property ($past(rst_n) |->
        link_sample[LINK_W-1:LINK_W-ADC_W+1] == $past(adc_sample[ADC_W-1:1]))
        else $error("sample latency wrong");
    wide_mf_a: assert property ($past(rst_n) && $past(mode_is_64b66b) && $past(mode_f) != 8'h00 |->
        multiframe_length == 16'((256 * $past(mode_e)) / $past(mode_f)))
        else $error("64b66b multiframe length wrong");
endmodule
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adlc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, adc_sample = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, cal_enable = 1'b0, mode_is_64b66b = 1'b0, frame_tick = 1'b0;
    logic sysref = 1'b0, timestamp_in = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] mode_e = 8'h01, mode_f = 8'h01;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dither_enable;
    logic dither_amplitude_select, dither_rounding_select, link_enable, link_reset_n;
    logic serializer_power_down, link_clock_enable, multiframe_boundary, ila_control_bits_zero;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [5:0] link_output_mode;
    logic [15:0] multiframe_length;
    logic [11:0] link_sample;
    int n_errors = 0, cmp_count = 0, k;
    // Link enable first, so it is off before other link settings change
    localparam logic [11:0] AD [5] = '{{IDX_LINK_EN, 2'b00}, {IDX_DITHER, 2'b00}, {IDX_LSB, 2'b00},
        {IDX_MODE, 2'b00}, {IDX_KM1, 2'b00}};
    localparam logic [7:0] RV [5] = '{RST_LINK_EN, RST_DITHER, RST_LSB, RST_MODE, RST_KM1};
    // Reserved bits kept at their reset value
    localparam logic [7:0] WV [5] = '{8'h00, 8'h05, 8'h01, 8'h25, 8'hA5};
    adlc_regs uut (.*);
    initial begin
        forever #2.5 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wrap_up();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: got %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (i == 50) begin
            n_errors++;
            wrap_up();
        end
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 50) begin
            n_errors++;
            wrap_up();
        end
        @(posedge clk);
    endtask
    task automatic pulse(input logic e);
        sysref <= 1'b1;
        @(posedge clk);
        sysref <= 1'b0;
        @(posedge clk);
        chk(multiframe_boundary, {31'h0, e});
        repeat (2) @(posedge clk);
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 5; k++) begin
            rd(AD[k]);
            chk(rv, {24'h0, RV[k]});
        end
        chk(multiframe_length, 32'h20);
        $display("reset test done");
        // Reserved bits left at zero; only field bits set to see them stored
        for (k = 0; k < 5; k++) begin
            wr(AD[k], WV[k]);
            rd(AD[k]);
            chk(rv, {24'h0, WV[k]});
        end
        chk({link_enable, link_reset_n, serializer_power_down, link_clock_enable}, 32'h2);
        chk(ila_control_bits_zero, 32'h1);
        pulse(1'b0);
        chk(link_output_mode, 32'h25);
        chk(multiframe_length, 32'hA6);
        cal_enable <= 1'b1;
        wr(AD[0], 8'h01);
        chk(link_enable, 32'h1);
        pulse(1'b1);
        // Counter starts from zero after the pulse; wrap after K ticks
        frame_tick <= 1'b1;
        repeat (int'(WV[4]) + 1) @(posedge clk);
        chk(multiframe_boundary, 32'h0);
        @(posedge clk);
        chk(multiframe_boundary, 32'h1);
        frame_tick <= 1'b0;
        $display("readback and link test done");
        for (k = 0; k < 3; k++) begin
            wr(AD[1], 8'h01 << k);
            chk({dither_rounding_select, dither_amplitude_select, dither_enable}, 32'h1 << k);
        end
        $display("dither test done");
        adc_sample <= 12'hABC;
        timestamp_in <= 1'b1;
        repeat (2) @(posedge clk);
        chk(link_sample, 32'hABD);
        adc_sample <= 12'hABD;
        timestamp_in <= 1'b0;
        repeat (2) @(posedge clk);
        chk(link_sample, 32'hABC);
        adc_sample <= 12'hABC;
        timestamp_in <= 1'b1;
        wr(AD[2], 8'h00);
        chk(link_sample, 32'hABC);
        $display("timestamp test done");
        mode_is_64b66b <= 1'b1;
        mode_e <= 8'h02;
        mode_f <= 8'h04;
        repeat (3) @(posedge clk);
        chk(multiframe_length, 32'h80);
        rd({IDX_KEFF, 2'b00});
        chk(rv, 32'h80);
        rd({IDX_STATUS, 2'b00});
        chk(rv, 32'hE);
        rd(12'hFFC);
        chk({rr, rv[29:0]}, {RESP_SLVERR, 30'h0});
        wr(12'hFFC, 8'h5A);
        chk(rr, RESP_SLVERR);
        $display("mode and unmapped test done");
        wrap_up();
    end
endmodule
bind adlc_regs adlc_regs_properties #(.ADC_W(ADC_W), .LINK_W(LINK_W)) u_props (.*);
`default_nettype wire
